/* hdl/supervisor_settings_command_parser.sv */
// Supervisor settings command parser: query, change and composite reply.
// Assumes byte streams from a UART on the same clock; registers over a plain port.
// How it works
// RULE1: A query is the address and the settings letters, X-prefixed and ended by ! in SDI-12.
// RULE2: A query reply echoes address and command, then R=, I=, S=, H= fields and CR LF.
// RULE3: The parameter selection is a 16-bit mask where one includes and zero excludes.
// RULE4: Mask bits 1-8 select the five supervisor items for the supervisor message.
// RULE5: Mask bits 9-16 select the same items for the composite message, halves split by &.
// RULE6: The interval accepts 1 to 3600 s and is forced to 15 s while heating is enabled.
// RULE7: The error-messaging flag is set by Y and cleared by N.
// RULE8: Heating flag Y allows full or half power, N keeps the heater off.
// RULE9: A change command carries any of R, I, S, H and is echoed in ASCII and NMEA.
// RULE10: In SDI-12 a change is acknowledged by the address and CR LF only.
// RULE11: A mask value starting with & changes bits 9-16 only; the echo shows all 16.
// RULE12: The composite reply holds every item whose composite selection bit is set.
// RULE13: The composite reply is address, code, name=value items with units, CR LF.
// RULE14: Commands carrying another device address are dropped without a reply.
`timescale 1ns/1ps
`include "sup_cmd_defines.svh"
module supervisor_settings_command_parser
  import sup_cmd_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  output logic rx_ready_out,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  input wire logic tx_ready_in,
  input wire item_val_t [4:0] sup_items_in,
  input wire logic heat_full_req_in,
  input wire reg_bus_t reg_bus_in,
  output logic [31:0] reg_rdata_out,
  output logic irq_out,
  output logic [4:0] sup_msg_sel_out,
  output logic [4:0] comp_sel_out,
  output logic [11:0] interval_out,
  output logic err_msg_en_out,
  output heat_level_t heat_level_out
);
  function automatic logic [7:0] yn_char(input logic b);
    return b ? `CH_Y : `CH_N;
  endfunction
  function automatic logic is_dec(input logic [7:0] ch);
    return ch >= `CH_ZERO && ch <= (`CH_ZERO + 8'h09);
  endfunction
  function automatic logic [15:0] item_name(input logic [2:0] i);
    case (i)
      3'h0: return `NAME_TH;
      3'h1: return `NAME_VH;
      3'h2: return `NAME_VS;
      3'h3: return `NAME_VR;
      default: return `NAME_ID;
    endcase
  endfunction

  logic [7:0] addr_ff, nxt_addr;
  logic [7:0] rbuf_ff [32];
  logic [7:0] obuf_ff [64];
  state_t state_ff, nxt_state;
  logic [5:0] len_ff, nxt_len, p_ff, nxt_p;
  logic [6:0] k_ff, nxt_k, olen_ff, nxt_olen, rdp_ff, nxt_rdp;
  logic sdi_ff, nxt_sdi, amp_ff, nxt_amp;
  logic [7:0] fld_ff, nxt_fld, txd_ff, nxt_txd;
  logic [4:0] dc_ff, nxt_dc, pre_ff, nxt_pre;
  logic [15:0] tmp_ff, nxt_tmp, tdig_ff, nxt_tdig, pm_ff, nxt_pm, pd_ff, nxt_pd;
  logic [13:0] acc_ff, nxt_acc;
  logic [11:0] pi_ff, nxt_pi, intv_ff, nxt_intv;
  logic ps_ff, nxt_ps, ph_ff, nxt_ph, s_ff, nxt_s, h_ff, nxt_h;
  logic [15:0] mask_ff, nxt_mask, dig_ff, nxt_dig;
  logic [2:0] it_ff, nxt_it;
  logic [3:0] sub_ff, nxt_sub;
  logic rb_we, ob_we, emit, bad, fmt_done, ev_chg, ev_ign, ev_ovf;
  logic [7:0] ch, c, c1;
  logic [4:0] h0, h1, h2;
  item_val_t itm;
  logic [15:0] nm;

  always_comb
  begin
    nxt_state = state_ff; nxt_len = len_ff; nxt_p = p_ff; nxt_k = k_ff;
    nxt_olen = olen_ff; nxt_rdp = rdp_ff; nxt_sdi = sdi_ff; nxt_amp = amp_ff;
    nxt_fld = fld_ff; nxt_txd = txd_ff; nxt_dc = dc_ff; nxt_pre = pre_ff;
    nxt_tmp = tmp_ff; nxt_tdig = tdig_ff; nxt_acc = acc_ff; nxt_pm = pm_ff;
    nxt_pd = pd_ff; nxt_pi = pi_ff; nxt_ps = ps_ff; nxt_ph = ph_ff;
    nxt_mask = mask_ff; nxt_dig = dig_ff; nxt_intv = intv_ff; nxt_s = s_ff;
    nxt_h = h_ff; nxt_it = it_ff; nxt_sub = sub_ff;
    rb_we = 1'b0; emit = 1'b0; bad = 1'b0; fmt_done = 1'b0; ch = `CH_LF;
    ev_chg = 1'b0; ev_ign = 1'b0; ev_ovf = 1'b0;
    h0 = sdi_ff ? 5'h02 : 5'h01;
    h1 = h0 + 5'h01;
    h2 = h0 + 5'h02;
    // Past the last stored byte the value ends as if a comma followed
    c = (p_ff < len_ff) ? rbuf_ff[p_ff[4:0]] : `CH_COMMA;
    c1 = rbuf_ff[5'(p_ff[4:0] + 5'h01)];
    itm = sup_items_in[it_ff];
    nm = item_name(it_ff);
    case (state_ff)
      ST_RECV:
      begin
        if (rx_valid_in && (rx_data_in == `CH_LF || rx_data_in == `CH_BANG))
        begin
          // An overflowed line ends here and is never decoded
          if (len_ff > `RXBUF_LEN)
            nxt_len = 6'h00;
          else
          begin
            nxt_sdi = (rx_data_in == `CH_BANG); // RULE1
            nxt_state = ST_HEAD;
          end
        end
        else if (rx_valid_in && rx_data_in != `CH_CR)
        begin
          // A line too long for the buffer is dropped whole
          if (len_ff >= `RXBUF_LEN)
          begin
            ev_ovf = (len_ff == `RXBUF_LEN);
            nxt_len = `RXBUF_LEN + 6'h01;
          end
          else
          begin
            rb_we = 1'b1;
            nxt_len = len_ff + 6'h01;
          end
        end
      end
      ST_HEAD:
      begin
        nxt_k = 7'h00;
        nxt_olen = 7'h00;
        nxt_it = 3'h0;
        nxt_sub = 4'h0;
        if (len_ff == 6'h00 || rbuf_ff[0] != addr_ff) // RULE14
          bad = 1'b1;
        else if (sdi_ff && rbuf_ff[1] != `CH_X) // RULE1
          bad = 1'b1;
        else if (rbuf_ff[h0] == `CH_S && rbuf_ff[h1] == `CH_U)
        begin
          if (len_ff == {1'b0, h2}) // RULE1
            nxt_state = ST_QRY;
          else if (rbuf_ff[h2] == `CH_COMMA) // RULE9
          begin
            nxt_p = {1'b0, h2} + 6'h01;
            nxt_fld = 8'h00;
            nxt_pm = mask_ff; nxt_pi = intv_ff; nxt_pd = dig_ff;
            nxt_ps = s_ff; nxt_ph = h_ff;
            nxt_state = ST_PARSE;
          end
          else
            bad = 1'b1;
        end
        else if (rbuf_ff[h0] == `CH_R && rbuf_ff[h1] == `CH_ZERO && len_ff == {1'b0, h2})
          nxt_state = ST_COMP;
        else
          bad = 1'b1;
      end
      ST_PARSE:
      begin
        if (fld_ff == 8'h00)
        begin
          if (p_ff + 6'h01 < len_ff && c1 == `CH_EQ &&
              (c == `CH_R || c == `CH_I || c == `CH_S || c == `CH_H)) // RULE9
          begin
            nxt_fld = c; nxt_p = p_ff + 6'h02; nxt_dc = 5'h00; nxt_pre = 5'h00;
            nxt_amp = 1'b0; nxt_tmp = 16'h0000; nxt_acc = 14'h0000; nxt_tdig = 16'h0000;
          end
          else
            bad = 1'b1;
        end
        else if (c == `CH_COMMA)
        begin
          case (fld_ff)
            `CH_R:
              if (dc_ff == `FULL_BITS && (!amp_ff || pre_ff == `HALF_BITS))
                nxt_pm = tmp_ff; // RULE3
              else if (amp_ff && pre_ff == 5'h00 && dc_ff == `HALF_BITS)
                nxt_pm = {pm_ff[15:8], tmp_ff[7:0]}; // RULE11
              else
                bad = 1'b1;
            `CH_I:
              if (dc_ff != 5'h00 && acc_ff >= `INTV_MIN && acc_ff <= `INTV_MAX) // RULE6
              begin
                nxt_pi = acc_ff[11:0];
                nxt_pd = tdig_ff;
              end
              else
                bad = 1'b1;
            `CH_S:
              if (dc_ff != 5'h00) nxt_ps = tmp_ff[0]; else bad = 1'b1; // RULE7
            default:
              if (dc_ff != 5'h00) nxt_ph = tmp_ff[0]; else bad = 1'b1; // RULE8
          endcase
          if (p_ff >= len_ff && !bad)
          begin
            // Settings change only once the whole command has parsed cleanly
            nxt_mask = nxt_pm; nxt_intv = nxt_pi; nxt_dig = nxt_pd;
            nxt_s = nxt_ps; nxt_h = nxt_ph; ev_chg = 1'b1;
            nxt_state = ST_ECHO;
          end
          nxt_fld = 8'h00;
          nxt_p = p_ff + 6'h01;
        end
        else
        begin
          nxt_p = p_ff + 6'h01;
          case (fld_ff)
            `CH_R:
              if (c == `CH_AMP && !amp_ff) // RULE5
              begin
                nxt_amp = 1'b1;
                nxt_pre = dc_ff;
              end
              else if ((c == `CH_ZERO || c == `CH_ONE) && dc_ff < `FULL_BITS)
              begin
                nxt_tmp = {tmp_ff[14:0], c[0]};
                nxt_dc = dc_ff + 5'h01;
              end
              else
                bad = 1'b1;
            `CH_I:
              if (is_dec(c) && dc_ff < `MAX_DIGITS)
              begin
                nxt_acc = 14'(acc_ff * `DEC_BASE + {10'h000, c[3:0]});
                nxt_tdig = {tdig_ff[11:0], c[3:0]};
                nxt_dc = dc_ff + 5'h01;
              end
              else
                bad = 1'b1;
            default:
              if ((c == `CH_Y || c == `CH_N) && dc_ff == 5'h00) // RULE7
              begin
                nxt_tmp = {15'h0000, c == `CH_Y};
                nxt_dc = 5'h01;
              end
              else
                bad = 1'b1;
          endcase
        end
      end
      ST_ECHO:
      begin
        emit = 1'b1;
        nxt_k = k_ff + 7'h01;
        // SDI-12 acknowledges with the address alone
        if (k_ff < (sdi_ff ? 7'h01 : {1'b0, len_ff})) // RULE9 RULE10
        begin
          ch = rbuf_ff[k_ff[4:0]];
          // A short mask form is echoed with the kept upper half spelt out
          if (!sdi_ff && ch == `CH_AMP && rbuf_ff[5'(k_ff[4:0] - 5'h01)] == `CH_EQ &&
              {1'b0, sub_ff} != `HALF_BITS) // RULE11
          begin
            ch = mask_ff[4'(4'hf - sub_ff)] ? `CH_ONE : `CH_ZERO;
            nxt_sub = sub_ff + 4'h1;
            nxt_k = k_ff;
          end
          else
            nxt_sub = 4'h0;
        end
        else if (k_ff == (sdi_ff ? 7'h01 : {1'b0, len_ff}))
          ch = `CH_CR;
        else
          fmt_done = 1'b1;
      end
      ST_QRY:
      begin
        emit = 1'b1;
        nxt_k = k_ff + 7'h01;
        case (k_ff) // RULE2
          7'd0: ch = addr_ff;
          7'd1: begin ch = `CH_X; emit = sdi_ff; end
          7'd2, 7'd32: ch = `CH_S;
          7'd3: ch = `CH_U;
          7'd4, 7'd24, 7'd31, 7'd35: ch = `CH_COMMA;
          7'd5: ch = `CH_R;
          7'd6, 7'd26, 7'd33, 7'd37: ch = `CH_EQ;
          7'd15: ch = `CH_AMP; // RULE5
          7'd25: ch = `CH_I;
          7'd27: begin ch = {`DIGIT_HI, dig_ff[15:12]}; emit = |dig_ff[15:12]; end
          7'd28: begin ch = {`DIGIT_HI, dig_ff[11:8]}; emit = |dig_ff[15:8]; end
          7'd29: begin ch = {`DIGIT_HI, dig_ff[7:4]}; emit = |dig_ff[15:4]; end
          7'd30: ch = {`DIGIT_HI, dig_ff[3:0]};
          7'd34: ch = yn_char(s_ff);
          7'd36: ch = `CH_H;
          7'd38: ch = yn_char(h_ff);
          7'd39: ch = `CH_CR;
          7'd40: fmt_done = 1'b1;
          default:
            if (k_ff < 7'd15)
              ch = mask_ff[4'(7'd22 - k_ff)] ? `CH_ONE : `CH_ZERO;
            else
              ch = mask_ff[4'(7'd23 - k_ff)] ? `CH_ONE : `CH_ZERO;
        endcase
      end
      ST_COMP:
      begin
        if (k_ff < 7'h03) // RULE13
        begin
          emit = 1'b1;
          nxt_k = k_ff + 7'h01;
          ch = (k_ff == 7'h00) ? addr_ff : (k_ff == 7'h01) ? `CH_R : `CH_ZERO;
        end
        else if (it_ff > `ITEM_LAST)
        begin
          emit = 1'b1;
          nxt_sub = sub_ff + 4'h1;
          ch = (sub_ff == 4'h0) ? `CH_CR : `CH_LF;
          fmt_done = (sub_ff != 4'h0);
        end
        else if (!mask_ff[3'(`ITEM_LAST + 3'h3 - it_ff)]) // RULE12
          nxt_it = it_ff + 3'h1;
        else
        begin
          emit = 1'b1;
          nxt_sub = (sub_ff == `ITEM_SUB_LAST) ? 4'h0 : sub_ff + 4'h1;
          nxt_it = (sub_ff == `ITEM_SUB_LAST) ? it_ff + 3'h1 : it_ff;
          case (sub_ff) // RULE13
            4'h0: ch = `CH_COMMA;
            4'h1: ch = nm[15:8];
            4'h2: ch = nm[7:0];
            4'h3: ch = `CH_EQ;
            4'h8: ch = itm.unit;
            default: ch = itm.txt[2'(4'h7 - sub_ff)];
          endcase
          emit = (ch != 8'h00);
        end
      end
      ST_SEND:
        if (tx_ready_in)
        begin
          if (rdp_ff == olen_ff - 7'h01)
          begin
            nxt_state = ST_RECV;
            nxt_len = 6'h00;
          end
          nxt_rdp = rdp_ff + 7'h01;
          nxt_txd = obuf_ff[6'(rdp_ff + 7'h01)];
        end
      default:
        nxt_state = ST_RECV;
    endcase
    if (emit)
      nxt_olen = olen_ff + 7'h01;
    if (fmt_done)
    begin
      nxt_state = ST_SEND;
      nxt_rdp = 7'h00;
      nxt_txd = obuf_ff[0];
    end
    if (bad)
    begin
      ev_ign = 1'b1;
      nxt_len = 6'h00;
      nxt_state = ST_RECV;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rb_we) rbuf_ff[len_ff[4:0]] <= rx_data_in;
    if (emit) obuf_ff[olen_ff[5:0]] <= ch;
    if (srst_in)
    begin
      state_ff <= ST_RECV; len_ff <= 6'h00; p_ff <= 6'h00; k_ff <= 7'h00;
      olen_ff <= 7'h00; rdp_ff <= 7'h00; sdi_ff <= 1'b0; amp_ff <= 1'b0;
      fld_ff <= 8'h00; txd_ff <= 8'h00; dc_ff <= 5'h00; pre_ff <= 5'h00;
      tmp_ff <= 16'h0000; tdig_ff <= 16'h0000; acc_ff <= 14'h0000; pm_ff <= `MASK_RST;
      pd_ff <= `DIG_RST; pi_ff <= `INTV_RST; ps_ff <= 1'b1; ph_ff <= 1'b1;
      mask_ff <= `MASK_RST; dig_ff <= `DIG_RST; intv_ff <= `INTV_RST; s_ff <= 1'b1;
      h_ff <= 1'b1; it_ff <= 3'h0; sub_ff <= 4'h0;
    end
    else
    begin
      state_ff <= nxt_state; len_ff <= nxt_len; p_ff <= nxt_p; k_ff <= nxt_k;
      olen_ff <= nxt_olen; rdp_ff <= nxt_rdp; sdi_ff <= nxt_sdi; amp_ff <= nxt_amp;
      fld_ff <= nxt_fld; txd_ff <= nxt_txd; dc_ff <= nxt_dc; pre_ff <= nxt_pre;
      tmp_ff <= nxt_tmp; tdig_ff <= nxt_tdig; acc_ff <= nxt_acc; pm_ff <= nxt_pm;
      pd_ff <= nxt_pd; pi_ff <= nxt_pi; ps_ff <= nxt_ps; ph_ff <= nxt_ph;
      mask_ff <= nxt_mask; dig_ff <= nxt_dig; intv_ff <= nxt_intv; s_ff <= nxt_s;
      h_ff <= nxt_h; it_ff <= nxt_it; sub_ff <= nxt_sub;
    end
  end

  logic [2:0] stat_ff, nxt_stat, imask_ff, nxt_imask;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [11:0] ieff_ff, nxt_ieff;
  heat_level_t heat_ff, nxt_heat;

  always_comb
  begin
    nxt_addr = addr_ff;
    nxt_imask = imask_ff;
    nxt_stat = stat_ff;
    nxt_rdata = 32'h0000_0000;
    if (reg_bus_in.wr && reg_bus_in.addr == `OFS_ADDR)
      nxt_addr = reg_bus_in.wdata[7:0];
    if (reg_bus_in.wr && reg_bus_in.addr == `OFS_IMASK)
      nxt_imask = reg_bus_in.wdata[2:0];
    if (reg_bus_in.wr && reg_bus_in.addr == `OFS_STAT)
      nxt_stat = stat_ff & ~reg_bus_in.wdata[2:0];
    // New events are ORed in last so a set in the clearing cycle survives
    nxt_stat[`EV_CHANGED] = nxt_stat[`EV_CHANGED] | ev_chg;
    nxt_stat[`EV_IGNORED] = nxt_stat[`EV_IGNORED] | ev_ign;
    nxt_stat[`EV_OVERFLOW] = nxt_stat[`EV_OVERFLOW] | ev_ovf;
    if (reg_bus_in.rd)
      case (reg_bus_in.addr)
        `OFS_ADDR: nxt_rdata = {24'h000000, addr_ff};
        `OFS_STAT: nxt_rdata = {29'h00000000, stat_ff};
        `OFS_IMASK: nxt_rdata = {29'h00000000, imask_ff};
        `OFS_SET: nxt_rdata = {14'h0000, h_ff, s_ff, mask_ff};
        `OFS_INTV: nxt_rdata = {20'h00000, intv_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    nxt_ieff = h_ff ? `INTV_HEAT : intv_ff; // RULE6
    nxt_heat = !h_ff ? HEAT_OFF : heat_full_req_in ? HEAT_FULL : HEAT_HALF; // RULE8
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      addr_ff <= `ADDR_RST; stat_ff <= 3'h0; imask_ff <= 3'h0;
      rdata_ff <= 32'h0000_0000; ieff_ff <= `INTV_HEAT; heat_ff <= HEAT_OFF;
    end
    else
    begin
      addr_ff <= nxt_addr; stat_ff <= nxt_stat; imask_ff <= nxt_imask;
      rdata_ff <= nxt_rdata; ieff_ff <= nxt_ieff; heat_ff <= nxt_heat;
    end
  end

  assign rx_ready_out = (state_ff == ST_RECV);
  assign tx_valid_out = (state_ff == ST_SEND);
  assign tx_data_out = txd_ff;
  assign reg_rdata_out = rdata_ff;
  assign irq_out = |(stat_ff & imask_ff);
  assign sup_msg_sel_out = mask_ff[15:11]; // RULE4
  assign comp_sel_out = mask_ff[7:3]; // RULE5
  assign interval_out = ieff_ff;
  assign err_msg_en_out = s_ff; // RULE7
  assign heat_level_out = heat_ff;

  property p_heat_off; // RULE8
    @(posedge core_clk_in) disable iff (srst_in) !h_ff |=> heat_level_out == HEAT_OFF;
  endproperty
  a_heat_off: assert property (p_heat_off) else $error("heater not off"); // RULE8
  property p_heat_full; // RULE8
    @(posedge core_clk_in) disable iff (srst_in)
      (h_ff && heat_full_req_in) |=> heat_level_out == HEAT_FULL;
  endproperty
  a_heat_full: assert property (p_heat_full) else $error("heater not full"); // RULE8
  property p_intv_heat; // RULE6
    @(posedge core_clk_in) disable iff (srst_in) h_ff |=> interval_out == `INTV_HEAT;
  endproperty
  a_intv_heat: assert property (p_intv_heat) else $error("interval not forced"); // RULE6
  property p_intv_range; // RULE6
    @(posedge core_clk_in) disable iff (srst_in)
      {2'b00, intv_ff} >= `INTV_MIN && {2'b00, intv_ff} <= `INTV_MAX;
  endproperty
  a_intv_range: assert property (p_intv_range) else $error("interval out of range"); // RULE6
  property p_addr_ign; // RULE14
    @(posedge core_clk_in) disable iff (srst_in)
      (state_ff == ST_HEAD && rbuf_ff[0] != addr_ff) |=> state_ff == ST_RECV && len_ff == 6'h00;
  endproperty
  a_addr_ign: assert property (p_addr_ign) else $error("foreign address answered"); // RULE14
  property p_keep_hi; // RULE11
    @(posedge core_clk_in) disable iff (srst_in)
      (state_ff == ST_PARSE && fld_ff == `CH_R && c == `CH_COMMA && amp_ff &&
       pre_ff == 5'h00 && dc_ff == `HALF_BITS)
      |=> pm_ff[15:8] == $past(pm_ff[15:8]) && pm_ff[7:0] == $past(tmp_ff[7:0]);
  endproperty
  a_keep_hi: assert property (p_keep_hi) else $error("upper mask half changed"); // RULE11
  sequence s_ack_out;
    (state_ff == ST_ECHO)[*3] ##1 (state_ff == ST_SEND && olen_ff == 7'h03);
  endsequence
  property p_sdi_ack; // RULE10
    @(posedge core_clk_in) disable iff (srst_in)
      (state_ff == ST_PARSE && nxt_state == ST_ECHO && sdi_ff) |=> s_ack_out;
  endproperty
  a_sdi_ack: assert property (p_sdi_ack) else $error("bad SDI-12 acknowledge"); // RULE10
  property p_lf_last; // RULE2
    @(posedge core_clk_in) disable iff (srst_in)
      (tx_valid_out && rdp_ff == olen_ff - 7'h01) |-> tx_data_out == `CH_LF;
  endproperty
  a_lf_last: assert property (p_lf_last) else $error("reply not ended by LF"); // RULE2
  property p_set_wins;
    @(posedge core_clk_in) disable iff (srst_in) ev_ign |=> stat_ff[`EV_IGNORED];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");
endmodule

/* common/sup_cmd_defines.svh */
// Shared constants of the supervisor settings command parser.
// Assumes ASCII byte streams and a 32-bit register port.
`ifndef SUP_CMD_DEFINES_SVH
`define SUP_CMD_DEFINES_SVH
`define CH_CR 8'h0d
`define CH_LF 8'h0a
`define CH_BANG 8'h21
`define CH_COMMA 8'h2c
`define CH_EQ 8'h3d
`define CH_AMP 8'h26
`define CH_ZERO 8'h30
`define CH_ONE 8'h31
`define CH_X 8'h58
`define CH_S 8'h53
`define CH_U 8'h55
`define CH_R 8'h52
`define CH_I 8'h49
`define CH_H 8'h48
`define CH_Y 8'h59
`define CH_N 8'h4e
`define DIGIT_HI 4'h3
`define NAME_TH 16'h5468
`define NAME_VH 16'h5668
`define NAME_VS 16'h5673
`define NAME_VR 16'h5672
`define NAME_ID 16'h4964
`define ITEM_LAST 3'h4
`define ITEM_SUB_LAST 4'h8
`define RXBUF_LEN 6'h20
`define HALF_BITS 5'h08
`define FULL_BITS 5'h10
`define MAX_DIGITS 5'h04
`define DEC_BASE 14'h000a
`define INTV_MIN 14'h0001
`define INTV_MAX 14'h0e10
`define INTV_HEAT 12'h00f
`define MASK_RST 16'hf0c0
`define INTV_RST 12'h00f
`define DIG_RST 16'h0015
`define ADDR_RST 8'h30
`define OFS_ADDR 5'h00
`define OFS_STAT 5'h04
`define OFS_IMASK 5'h08
`define OFS_SET 5'h0c
`define OFS_INTV 5'h10
`define EV_CHANGED 0
`define EV_IGNORED 1
`define EV_OVERFLOW 2
`endif

/* common/sup_cmd_pkg.sv */
// Types of the supervisor settings command parser.
// Assumes the constants header is compiled alongside.
package sup_cmd_pkg;
  typedef enum logic [2:0] {
    ST_RECV, ST_HEAD, ST_PARSE, ST_ECHO, ST_QRY, ST_COMP, ST_SEND
  } state_t;
  typedef enum logic [1:0] {HEAT_OFF, HEAT_HALF, HEAT_FULL} heat_level_t;
  typedef struct packed {
    logic [3:0][7:0] txt;
    logic [7:0] unit;
  } item_val_t;
  typedef struct packed {
    logic [4:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_bus_t;
endpackage

/* tb/serial_host.sv */
// Host model on the serial line: sends command lines, collects replies.
// Assumes the block samples and updates on the rising edge of core_clk_in.
`timescale 1ns/1ps
module serial_host
(
  input wire logic core_clk_in,
  input wire logic rx_ready_in,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out
);
  initial
  begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    tx_ready_out = 1'b1;
  end
  // Each byte stands until the edge that takes it; line ends as the caller typed it
  task automatic send_line(input string s, output bit ok);
    int n;
    ok = 1'b1;
    for (int i = 0; i < s.len(); i++)
    begin
      rx_valid_out <= 1'b1;
      rx_data_out <= s[i];
      n = 0;
      do
      begin
        @(posedge core_clk_in);
        n++;
      end
      while (!rx_ready_in && n < 200);
      if (n >= 200)
        ok = 1'b0;
    end
    rx_valid_out <= 1'b0;
    // Released line must not keep showing the last byte
    rx_data_out <= ~rx_data_out;
  endtask
  // Stall halves the sink rate, so the reply must hold each byte
  task automatic get_reply(input bit stall, input int limit, output string r, output bit ok);
    r = "";
    ok = 1'b0;
    for (int n = 0; n < limit && !ok; n++)
    begin
      @(posedge core_clk_in);
      if (tx_valid_in && tx_ready_out)
      begin
        r = $sformatf("%s%c", r, tx_data_in);
        ok = (tx_data_in === 8'h0a);
      end
      tx_ready_out <= (stall && !ok) ? ~tx_ready_out : 1'b1;
    end
  endtask
endmodule

/* tb/supervisor_settings_command_parser_bench.sv */
// Bench of the supervisor settings command parser.
// Assumes the serial host model; register port driven here.
`timescale 1ns/1ps
module supervisor_settings_command_parser_bench;
  import sup_cmd_pkg::*;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic heat_full = 1'b0;
  logic rx_valid, rx_ready, tx_valid, tx_ready, irq, err_en;
  logic [7:0] rx_data, tx_data;
  logic [31:0] rdata, d;
  logic [4:0] sup_sel, comp_sel;
  logic [11:0] intv;
  heat_level_t heat;
  reg_bus_t bus = '0;
  item_val_t [4:0] items = {40'h48454c0000, 40'h0, 40'h31322e3056, 80'h0};
  int error_cnt = 0;
  int n_checks = 0;
  string eol = "\015\n";
  string q = ",R=11110000&11000000,I=15,S=Y,H=Y";
  always #4 core_clk_in = ~core_clk_in;
  supervisor_settings_command_parser i_dut (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .rx_valid_in(rx_valid), .rx_data_in(rx_data), .rx_ready_out(rx_ready),
    .tx_valid_out(tx_valid), .tx_data_out(tx_data), .tx_ready_in(tx_ready),
    .sup_items_in(items), .heat_full_req_in(heat_full), .reg_bus_in(bus),
    .reg_rdata_out(rdata), .irq_out(irq), .sup_msg_sel_out(sup_sel),
    .comp_sel_out(comp_sel), .interval_out(intv), .err_msg_en_out(err_en),
    .heat_level_out(heat));
  serial_host i_host (.core_clk_in(core_clk_in), .rx_ready_in(rx_ready),
    .rx_valid_out(rx_valid), .rx_data_out(rx_data), .tx_valid_in(tx_valid),
    .tx_data_in(tx_data), .tx_ready_out(tx_ready));
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Empty expectation means the line must be dropped without any reply
  task automatic cmd(input string c, input string exp, input bit stall);
    string r;
    bit ok;
    i_host.send_line(c, ok);
    if (!ok)
      error_cnt++;
    if (!ok)
      close_out();
    i_host.get_reply(stall, 400, r, ok);
    if (exp != "")
      exp = {exp, eol};
    n_checks++;
    if (r != exp || (!ok && exp != ""))
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, r, exp);
    end
  endtask
  // Two edges per access keep the strobe from being assigned twice in one step
  task automatic reg_wr(input logic [4:0] a, input logic [31:0] v);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_in);
    bus <= '0;
    @(posedge core_clk_in);
  endtask
  task automatic reg_rd(input logic [4:0] a, output logic [31:0] v);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_in);
    bus <= '0;
    @(posedge core_clk_in);
    v = rdata;
  endtask
  task automatic t_reset();
    reg_rd(5'h0c, d);
    chk(d, 32'h0003f0c0);
    chk(sup_sel, 32'h1e);
    chk(comp_sel, 32'h18);
    chk(intv, 32'h00f);
    chk(err_en, 32'h1);
    chk(heat, HEAT_HALF);
    reg_rd(5'h14, d);
    chk(d, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_query();
    cmd({"0SU", eol}, {"0SU", q}, 1'b1);
    cmd("0XSU!", {"0XSU", q}, 1'b0);
    $display("test query done");
  endtask
  task automatic t_change();
    cmd({"0SU,S=N,H=N", eol}, "0SU,S=N,H=N", 1'b1);
    chk(err_en, 32'h0);
    chk(heat, HEAT_OFF);
    reg_wr(5'h08, 32'h0);
    chk(irq, 32'h0);
    reg_rd(5'h04, d);
    chk(d[2:0], 32'h1);
    reg_wr(5'h08, 32'h1);
    chk(irq, 32'h1);
    reg_wr(5'h04, 32'h1);
    chk(irq, 32'h0);
    cmd("0XSU,I=10!", "0", 1'b0);
    chk(intv, 32'h00a);
    $display("test change done");
  endtask
  task automatic t_bad();
    cmd({"0SU,I=3601", eol}, "", 1'b0);
    cmd({"1SU", eol}, "", 1'b0);
    cmd({"0SU,I=10,I=10,I=10,I=10,I=10,I=10,I=10", eol}, "", 1'b0);
    reg_rd(5'h04, d);
    chk(d[2:0], 32'h7);
    reg_rd(5'h10, d);
    chk(d, 32'h00a);
    cmd({"0SU,I=3600,H=Y", eol}, "0SU,I=3600,H=Y", 1'b0);
    heat_full <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    chk(intv, 32'h00f);
    chk(heat, HEAT_FULL);
    reg_rd(5'h10, d);
    chk(d, 32'he10);
    $display("test refusal done");
  endtask
  task automatic t_comp();
    cmd({"0SU,R=&00101000", eol}, "0SU,R=11110000&00101000", 1'b0);
    chk(comp_sel, 32'h05);
    chk(sup_sel, 32'h1e);
    cmd({"0R0", eol}, "0R0,Vs=12.0V,Id=HEL", 1'b1);
    $display("test composite done");
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk_in);
    srst_in <= 1'b0;
    t_reset();
    t_query();
    t_change();
    t_bad();
    t_comp();
    close_out();
  end
endmodule
